// [hw/sram_port_pkg.sv]
package sram_port_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // organisation defaults and lane layout
    localparam int DATA_WIDTH_DEF = 36;   // 512K x 36 organisation
    localparam int ADDR_WIDTH_DEF = 19;   // 524,288 words
    localparam int LANE_BITS      = 9;    // eight data bits plus one parity bit
    localparam int BEAT_BITS      = 2;    // burst counter width
    localparam int FIFO_DEPTH_DEF = 16;   // write queue depth in words

    ////////////////////////////////////////////////////////////////////////////////
    // timing and encodings
    localparam int   DATA_DELAY   = 2;    // cycles from address to data
    localparam logic ORDER_LINEAR = 1'b0; // burst-order level for linear order
    localparam logic [1:0] BEAT_START = 2'h0;
    localparam logic [1:0] BEAT_STEP  = 2'h1;

    // burst sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_READ  = 3'h2,
        ST_WRITE = 3'h4
    } burst_state_type;

endpackage

// [hw/word_fifo.sv]
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    // clock, reset and freeze
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             enable,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_q [0:DEPTH-1]; // entries, no reset needed
    logic [PW-1:0]    wr_ptr_q, wr_ptr_d;  // next slot to fill
    logic [PW-1:0]    rd_ptr_q, rd_ptr_d;  // head slot
    logic [PW:0]      count_q, count_d;    // occupancy, one bit wider for full
    logic             push, pop;

    ////////////////////////////////////////////////////////////////////////////////
    // flags and moves; a frozen cycle moves nothing
    assign in_ready  = (count_q != DEPTH[PW:0]);
    assign out_valid = (count_q != '0);
    assign out_data  = store_q[rd_ptr_q];
    assign push      = enable && in_valid && in_ready;
    assign pop       = enable && out_valid && out_ready;

    // pointer and count next values
    always_comb begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d  = count_q;
        if (push) begin
            wr_ptr_d = (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
        end
        if (pop) begin
            rd_ptr_d = (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
        end
        // push and pop together leave the count alone
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    // pointer registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
        end
    end

    // storage write
    always_ff @(posedge mclk) begin
        if (push) begin
            store_q[wr_ptr_q] <= in_data;
        end
    end

    fifo_bound_a: assert property (@(posedge mclk) disable iff (reset)
        count_q <= DEPTH[PW:0]) else $error("write queue count above depth");

endmodule

// [hw/pipelined_burst_sram_port.sv]
`timescale 1ns/1ps
module pipelined_burst_sram_port #(
    parameter int DATA_WIDTH = sram_port_pkg::DATA_WIDTH_DEF, // 36 or 18
    parameter int ADDR_WIDTH = sram_port_pkg::ADDR_WIDTH_DEF, // 19 or 20
    parameter int FIFO_DEPTH = sram_port_pkg::FIFO_DEPTH_DEF
) (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset,
    // clock hold, low lets the block run
    input  wire logic                  clock_hold_n,
    // address and control, sampled together
    input  wire logic [ADDR_WIDTH-1:0] addr,
    input  wire logic                  advance_or_load,
    input  wire logic                  write_n,
    input  wire logic                  chip_select_a_n,
    input  wire logic                  chip_select_b,
    input  wire logic                  chip_select_c_n,
    input  wire logic [DATA_WIDTH/sram_port_pkg::LANE_BITS-1:0] byte_lane_write_n,
    // static and asynchronous controls
    input  wire logic                  burst_order,
    input  wire logic                  output_drive_n,
    input  wire logic                  sleep_request,
    // data bus split into its three signals
    input  wire logic [DATA_WIDTH-1:0] data_in,
    output logic      [DATA_WIDTH-1:0] data_out,
    output logic                       data_oe,
    // write queue status
    output logic                       write_queue_ready,
    output logic                       write_queue_empty
);
    localparam int LANES = DATA_WIDTH / sram_port_pkg::LANE_BITS;
    localparam int LB    = sram_port_pkg::LANE_BITS;
    localparam int QW    = ADDR_WIDTH + LANES + DATA_WIDTH;       // queue word width

    ////////////////////////////////////////////////////////////////////////////////
    // burst low address bits from base and beat
    function automatic logic [1:0] burst_low(input logic [1:0] base,
                                             input logic [1:0] beat,
                                             input logic       order);
        logic [1:0] result;
        if (order == sram_port_pkg::ORDER_LINEAR) begin
            result = base + beat;
        end else begin
            result = base ^ beat;
        end
        return result;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    logic                                 en;          // high while not held
    logic                                 selected;    // all three selects active
    logic                                 load;        // load cycle, not advance
    sram_port_pkg::burst_state_type       state_q, state_d;
    logic [ADDR_WIDTH-1:0]                base_q, base_d;   // loaded burst address
    logic [1:0]                           beat_q, beat_d;   // two-bit burst counter
    // stage one: the operation taken at this edge
    logic                                 s1_valid_q, s1_valid_d;
    logic                                 s1_write_q, s1_write_d;
    logic [ADDR_WIDTH-1:0]                s1_addr_q, s1_addr_d;
    logic [LANES-1:0]                     s1_mask_q, s1_mask_d;
    // stage two: one cycle older, acts at the next edge
    logic                                 s2_valid_q, s2_valid_d;
    logic                                 s2_write_q, s2_write_d;
    logic [ADDR_WIDTH-1:0]                s2_addr_q, s2_addr_d;
    logic [LANES-1:0]                     s2_mask_q, s2_mask_d;
    // read output register
    logic                                 read_out_q, read_out_d;
    logic [DATA_WIDTH-1:0]                rdata_q, rdata_d;
    // write queue and array
    logic                                 push_valid;
    logic [QW-1:0]                        push_word;
    logic                                 head_valid;
    logic                                 head_ready;
    logic [QW-1:0]                        head_word;
    logic [ADDR_WIDTH-1:0]                head_addr;
    logic [LANES-1:0]                     head_mask;
    logic [DATA_WIDTH-1:0]                head_data;
    logic                                 drain_fire;
    logic [DATA_WIDTH-1:0]                array_word;  // raw array read
    logic [DATA_WIDTH-1:0]                merged_word; // array with queued write merged
    logic                                 head_hit;
    logic [DATA_WIDTH-1:0]                mem_q [0:(1<<ADDR_WIDTH)-1];

    ////////////////////////////////////////////////////////////////////////////////
    // input decode; inputs come from logic on this clock, so no synchroniser
    assign en       = !clock_hold_n;
    assign selected = !chip_select_a_n && chip_select_b && !chip_select_c_n;
    assign load     = !advance_or_load;

    // burst sequencer and stage one next values
    always_comb begin
        state_d    = state_q;
        base_d     = base_q;
        beat_d     = beat_q;
        s1_valid_d = 1'b0;
        s1_write_d = s1_write_q;
        s1_addr_d  = s1_addr_q;
        s1_mask_d  = s1_mask_q;
        if (sleep_request) begin
            // asleep: nothing new starts and any burst is dropped
            state_d = sram_port_pkg::ST_IDLE;
        end else if (load) begin
            if (selected) begin
                // new address, burst counter back to its first beat
                state_d    = write_n ? sram_port_pkg::ST_READ : sram_port_pkg::ST_WRITE;
                base_d     = addr;
                beat_d     = sram_port_pkg::BEAT_START;
                s1_valid_d = 1'b1;
                s1_write_d = !write_n;
                s1_addr_d  = addr;
                s1_mask_d  = ~byte_lane_write_n;
            end else begin
                // deselect ends the burst; the pipeline still drains
                state_d = sram_port_pkg::ST_IDLE;
            end
        end else begin
            unique case (state_q)
                sram_port_pkg::ST_IDLE: begin
                    // advance with no burst open does nothing
                end
                sram_port_pkg::ST_READ, sram_port_pkg::ST_WRITE: begin
                    // next beat; the counter wraps after four beats
                    beat_d     = beat_q + sram_port_pkg::BEAT_STEP;
                    s1_valid_d = 1'b1;
                    s1_write_d = (state_q == sram_port_pkg::ST_WRITE);
                    s1_addr_d  = {base_q[ADDR_WIDTH-1:2],
                                  burst_low(base_q[1:0], beat_d, burst_order)};
                    s1_mask_d  = ~byte_lane_write_n;
                end
                default: begin
                    // illegal code, recover to idle
                    state_d = sram_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // sequencer and stage one registers, frozen while held
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q    <= sram_port_pkg::ST_IDLE;
            base_q     <= '0;
            beat_q     <= sram_port_pkg::BEAT_START;
            s1_valid_q <= 1'b0;
            s1_write_q <= 1'b0;
            s1_addr_q  <= '0;
            s1_mask_q  <= '0;
        end else if (en) begin
            state_q    <= state_d;
            base_q     <= base_d;
            beat_q     <= beat_d;
            s1_valid_q <= s1_valid_d;
            s1_write_q <= s1_write_d;
            s1_addr_q  <= s1_addr_d;
            s1_mask_q  <= s1_mask_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pipeline: stage two and the read output register
    always_comb begin
        s2_valid_d = s1_valid_q;
        s2_write_d = s1_write_q;
        s2_addr_d  = s1_addr_q;
        s2_mask_d  = s1_mask_q;
        // read data lands two edges after the address was taken
        read_out_d = s2_valid_q && !s2_write_q;
        rdata_d    = rdata_q;
        if (s2_valid_q && !s2_write_q) begin
            rdata_d = merged_word;
        end
    end

    // pipeline registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s2_valid_q <= 1'b0;
            s2_write_q <= 1'b0;
            s2_addr_q  <= '0;
            s2_mask_q  <= '0;
            read_out_q <= 1'b0;
            rdata_q    <= '0;
        end else if (en) begin
            s2_valid_q <= s2_valid_d;
            s2_write_q <= s2_write_d;
            s2_addr_q  <= s2_addr_d;
            s2_mask_q  <= s2_mask_d;
            read_out_q <= read_out_d;
            rdata_q    <= rdata_d;
        end
    end

    // bus drive: only read slots drive, and the disable cuts it off unclocked
    assign data_out = rdata_q;
    assign data_oe  = read_out_q && !output_drive_n;

    ////////////////////////////////////////////////////////////////////////////////
    // write path: data taken at the data edge joins the queue
    assign push_valid = s2_valid_q && s2_write_q;
    assign push_word  = {s2_addr_q, s2_mask_q, data_in};
    // draining stops while asleep, which is what lets the queue fill
    assign head_ready = !sleep_request;
    assign drain_fire = en && head_valid && head_ready;
    assign head_addr  = head_word[QW-1 -: ADDR_WIDTH];
    assign head_mask  = head_word[DATA_WIDTH +: LANES];
    assign head_data  = head_word[DATA_WIDTH-1:0];
    assign write_queue_empty = !head_valid;

    word_fifo #(
        .WIDTH (QW),
        .DEPTH (FIFO_DEPTH)
    ) write_queue (
        .mclk      (mclk),
        .reset     (reset),
        .enable    (en),
        .in_valid  (push_valid),
        .in_ready  (write_queue_ready),
        .in_data   (push_word),
        .out_valid (head_valid),
        .out_ready (head_ready),
        .out_data  (head_word)
    );

    // array write, one lane select per byte lane
    always_ff @(posedge mclk) begin
        if (drain_fire) begin
            for (int l = 0; l < LANES; l++) begin
                if (head_mask[l]) begin
                    mem_q[head_addr][l*LB +: LB] <= head_data[l*LB +: LB];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read with bypass: a write still at the queue head is newer than the array,
    // so its enabled lanes replace the array lanes; this keeps read after write
    // coherent with no idle cycle in between, except when a sleep-stalled drain leaves an older write at the head
    assign array_word = mem_q[s2_addr_q];
    assign head_hit   = head_valid && (head_addr == s2_addr_q);

    for (genvar g = 0; g < LANES; g++) begin : g_merge
        assign merged_word[g*LB +: LB] = (head_hit && head_mask[g]) ?
                                         head_data[g*LB +: LB] :
                                         array_word[g*LB +: LB];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    hold_freeze_a: assert property (@(posedge mclk) disable iff (reset)
        clock_hold_n |=> $stable(state_q) && $stable(beat_q) && $stable(s2_addr_q)
                         && $stable(rdata_q) && $stable(read_out_q))
        else $error("state moved while clock hold was high");

    read_delay_a: assert property (@(posedge mclk) disable iff (reset)
        (en && s1_valid_d && !s1_write_d) ##1 en ##1 en |=> read_out_q)
        else $error("read data not driven two cycles after address");

    write_delay_a: assert property (@(posedge mclk) disable iff (reset)
        (en && s1_valid_d && s1_write_d) ##1 en ##1 en |-> push_valid)
        else $error("write data not taken two cycles after address");

    deselect_idle_a: assert property (@(posedge mclk) disable iff (reset)
        (en && load && !selected) |=> (state_q == sram_port_pkg::ST_IDLE) && !s1_valid_q)
        else $error("deselect did not stop the operation");

    pending_drain_a: assert property (@(posedge mclk) disable iff (reset)
        (en && s1_valid_q && !s1_write_q) ##1 en |=> read_out_q)
        else $error("pending read dropped");

    bus_release_a: assert property (@(posedge mclk) disable iff (reset)
        (en && !(s2_valid_q && !s2_write_q)) |=> !data_oe)
        else $error("bus driven in a slot with no read");

    beat_advance_a: assert property (@(posedge mclk) disable iff (reset)
        (en && !load && !sleep_request && (state_q != sram_port_pkg::ST_IDLE))
        |=> s1_valid_q && (beat_q == $past(beat_q) + 2'h1))
        else $error("burst counter did not advance");

    burst_order_a: assert property (@(posedge mclk) disable iff (reset)
        s1_valid_q |-> s1_addr_q[1:0] == ((burst_order == sram_port_pkg::ORDER_LINEAR) ?
                       2'(base_q[1:0] + beat_q) : (base_q[1:0] ^ beat_q)))
        else $error("burst address out of order");

    drive_cutoff_a: assert property (@(posedge mclk) disable iff (reset)
        output_drive_n |-> !data_oe)
        else $error("data driven while drive disabled");

    // a write data slot never drives the bus
    write_quiet_a: assert property (@(posedge mclk) disable iff (reset)
        (en && push_valid) |=> !read_out_q)
        else $error("bus driven in a write data slot");

    // an advance outside a burst is ignored
    stray_advance_a: assert property (@(posedge mclk) disable iff (reset)
        (en && !load && state_q == sram_port_pkg::ST_IDLE) |=> !s1_valid_q)
        else $error("advance with no open burst started an operation");

endmodule

// [bench/host_model.sv]
`timescale 1ns/1ps
// host side of the port: presents ops, feeds write data, collects read slots
module host_model #(
    parameter int DW = 36,
    parameter int AW = 19,
    parameter int LN = 4
) (
    // clock
    input  wire logic          mclk,
    // op and control
    output logic               clock_hold_n,
    output logic [AW-1:0]      addr,
    output logic               advance_or_load,
    output logic               write_n,
    output logic               chip_select_a_n,
    output logic               chip_select_b,
    output logic               chip_select_c_n,
    output logic [LN-1:0]      byte_lane_write_n,
    // data bus
    output logic [DW-1:0]      data_in,
    input  wire logic [DW-1:0] data_out,
    input  wire logic          data_oe
);
    logic [1:0]    cur_kind;   // op now shown: 0 none, 1 read, 2 write
    logic [DW-1:0] cur_data;   // its write word
    logic [1:0]    kind_q [3]; // ops in flight, newest first
    logic [DW-1:0] wd_q   [3]; // their write words
    logic          fresh;      // an enabled edge has just passed
    logic [DW:0]   rd_q [$];   // {drive, word} of each read slot
    int            oe_err;     // drives seen outside read slots

    ////////////////////////////////////////////////////////////
    // idle deselected values from time zero
    initial begin
        clock_hold_n = 1'b0;
        addr = '0;
        advance_or_load = 1'b0;
        write_n = 1'b1;
        {chip_select_a_n, chip_select_b, chip_select_c_n} = 3'h6;
        byte_lane_write_n = '1;
        cur_kind = 2'h0;
        cur_data = '0;
        kind_q = '{default: 2'h0};
        wd_q = '{default: '0};
        fresh = 1'b0;
        oe_err = 0;
        data_in = '0;
    end

    // only enabled edges move the pipeline, as in the device
    always @(posedge mclk) begin
        if (!clock_hold_n) begin
            kind_q <= '{cur_kind, kind_q[0], kind_q[1]};
            wd_q <= '{cur_data, wd_q[0], wd_q[1]};
            fresh <= 1'b1;
        end
    end

    // write word two enabled edges after its op; otherwise a changing
    // pattern so a stale value never looks like valid data
    always @(negedge mclk) begin
        data_in <= (kind_q[1] == 2'h2) ? wd_q[1] : ~data_in;
    end

    // sample a beat after the falling edge so asynchronous effects land
    always @(negedge mclk) begin
        if (fresh) begin
            #1;
            if (kind_q[2] == 2'h1) begin
                rd_q.push_back({data_oe, data_out});
            end else if (data_oe === 1'b1) begin
                oe_err++;
            end
            fresh = 1'b0;
        end
    end

    // one op per cycle; address, control and lanes set together
    task automatic op(input logic [1:0] kind, input logic ld, input logic wn,
                      input logic [AW-1:0] a, input logic [LN-1:0] lanes,
                      input logic [2:0] sel, input logic [DW-1:0] d, input logic hold);
        @(negedge mclk);
        clock_hold_n = hold;
        advance_or_load = ld;
        write_n = wn;
        addr = a;
        byte_lane_write_n = lanes;
        {chip_select_a_n, chip_select_b, chip_select_c_n} = sel;
        cur_kind = kind;
        cur_data = d;
    endtask
endmodule

// [bench/tb_pipelined_burst_sram_port.sv]
`timescale 1ns/1ps
// self-checking bench; expected memory contents are kept here
module tb_pipelined_burst_sram_port;
    localparam int DW = 36;                        // wide organisation
    localparam int AW = 19;
    localparam int LB = sram_port_pkg::LANE_BITS;
    localparam int LN = DW / LB;                   // byte lanes
    localparam logic [DW-1:0] JUNK = 36'hF_0F0F_0F0F;

    // clock, reset and static controls
    logic          mclk, reset, sleep_request, burst_order, output_drive_n;
    // op port, driven by the host model
    logic          clock_hold_n, advance_or_load, write_n;
    logic          chip_select_a_n, chip_select_b, chip_select_c_n;
    logic [AW-1:0] addr;
    logic [LN-1:0] byte_lane_write_n;
    // data and queue status
    logic [DW-1:0] data_in, data_out;
    logic          data_oe, write_queue_ready, write_queue_empty;
    // bookkeeping
    int            mismatches, checks_done, cycles;
    logic [DW-1:0] mem_exp [int];                  // expected array contents
    logic [DW:0]   exp_q [$];                      // expected read slots

    pipelined_burst_sram_port #(.DATA_WIDTH(DW), .ADDR_WIDTH(AW), .FIFO_DEPTH(16))
    i_pipelined_burst_sram_port (
        .mclk(mclk), .reset(reset), .clock_hold_n(clock_hold_n), .addr(addr),
        .advance_or_load(advance_or_load), .write_n(write_n),
        .chip_select_a_n(chip_select_a_n), .chip_select_b(chip_select_b),
        .chip_select_c_n(chip_select_c_n), .byte_lane_write_n(byte_lane_write_n),
        .burst_order(burst_order), .output_drive_n(output_drive_n),
        .sleep_request(sleep_request), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .write_queue_ready(write_queue_ready),
        .write_queue_empty(write_queue_empty));

    host_model #(.DW(DW), .AW(AW), .LN(LN)) i_host_model (
        .mclk(mclk), .clock_hold_n(clock_hold_n), .addr(addr),
        .advance_or_load(advance_or_load), .write_n(write_n),
        .chip_select_a_n(chip_select_a_n), .chip_select_b(chip_select_b),
        .chip_select_c_n(chip_select_c_n), .byte_lane_write_n(byte_lane_write_n),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

    ////////////////////////////////////////////////////////////
    // compares, verdict and op helpers
    task automatic chk_word(input string name, input logic [DW:0] e, input logic [DW:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_bit(input string name, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %b seen %b", name, e, g);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // deselected load keeps the bus quiet and closes any burst
    task automatic idle(input int n);
        repeat (n) i_host_model.op(2'h0, 1'b0, 1'b1, '0, '1, 3'h6, '0, 1'b0);
    endtask

    // an advance shows a wrong address, which must be ignored
    task automatic wr(input logic adv, input int a, input logic [LN-1:0] ln, input logic [DW-1:0] d);
        logic [DW-1:0] m;
        m = mem_exp.exists(a) ? mem_exp[a] : '0;
        for (int i = 0; i < LN; i++) if (!ln[i]) m[i*LB +: LB] = d[i*LB +: LB];
        mem_exp[a] = m;
        i_host_model.op(2'h2, adv, 1'b0, adv ? ~AW'(a) : AW'(a), ln, 3'h2, d, 1'b0);
    endtask

    task automatic rd(input logic adv, input int a, input logic oe);
        exp_q.push_back({oe, mem_exp[a]});
        i_host_model.op(2'h1, adv, 1'b1, adv ? ~AW'(a) : AW'(a), '1, 3'h2, '0, 1'b0);
    endtask

    task automatic finish_reads(input string name);
        logic [DW:0] e;
        logic [DW:0] g;
        idle(4);
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            g = (i_host_model.rd_q.size() > 0) ? i_host_model.rd_q.pop_front() : 'x;
            if (!e[DW]) g[DW-1:0] = e[DW-1:0];   // word is don't-care when undriven
            chk_word(name, e, g);
        end
        chk_bit("extra read slot", 1'b0, i_host_model.rd_q.size() > 0);
    endtask

    ////////////////////////////////////////////////////////////
    // scenarios
    task automatic s_basic();
        wr(1'b0, 16, '0, 36'h1_2345_6789);
        rd(1'b0, 16, 1'b1);
        wr(1'b0, 17, '0, 36'hE_DCBA_9876);
        rd(1'b0, 17, 1'b1);
        rd(1'b0, 16, 1'b1);
        finish_reads("basic word");
    endtask

    task automatic s_burst();
        for (int i = 0; i < 4; i++) wr(i != 0, 32 + (2 + i) % 4, '0, 36'hA00 + DW'(i));
        idle(3);
        burst_order = 1'b1;
        for (int i = 0; i < 4; i++) rd(i != 0, 32 + (1 ^ i), 1'b1);
        idle(3);
        burst_order = 1'b0;
        for (int i = 0; i < 5; i++) rd(i != 0, 32 + (3 + i) % 4, 1'b1);
        finish_reads("burst word");
    endtask

    task automatic s_lanes();
        wr(1'b0, 40, '0, 36'hF_FFFF_FFFF);
        for (int i = 0; i < LN; i++) begin
            wr(1'b0, 40, ~(LN'(1) << i), 36'h1_2345_6789 ^ DW'(i));
            rd(1'b0, 40, 1'b1);
        end
        finish_reads("lane word");
    endtask

    // writes shown while frozen must leave the word alone
    task automatic s_hold();
        wr(1'b0, 48, '0, 36'h5_A5A5_A5A5);
        rd(1'b0, 48, 1'b1);
        repeat (3) i_host_model.op(2'h0, 1'b0, 1'b0, AW'(48), '0, 3'h2, JUNK, 1'b1);
        rd(1'b0, 48, 1'b1);
        finish_reads("held word");
    endtask

    task automatic s_deselect();
        logic [2:0] pat [3] = '{3'h6, 3'h0, 3'h3};
        wr(1'b0, 56, '0, 36'h3_3333_3333);
        wr(1'b1, 57, '0, 36'h4_4444_4444);
        for (int i = 0; i < 3; i++) begin
            rd(1'b0, 56, 1'b1);
            rd(1'b1, 57, 1'b1);
            i_host_model.op(2'h0, 1'b0, 1'b0, AW'(56), '0, pat[i], JUNK, 1'b0);
            i_host_model.op(2'h0, 1'b1, 1'b1, AW'(57), '1, 3'h2, '0, 1'b0);
        end
        finish_reads("deselect word");
        chk_bit("stray drive", 1'b0, i_host_model.oe_err != 0);
    endtask

    // disable lands mid-cycle, no clock edge in between
    task automatic s_odis();
        rd(1'b0, 16, 1'b0);
        idle(3);
        output_drive_n = 1'b1;
        idle(1);
        output_drive_n = 1'b0;
        rd(1'b0, 16, 1'b1);
        finish_reads("disabled word");
    endtask

    // queued writes wait out the sleep, then drain
    task automatic s_sleep();
        wr(1'b0, 64, '0, 36'h6_6666_6666);
        wr(1'b0, 65, '0, 36'h7_7777_7777);
        idle(1);
        sleep_request = 1'b1;
        i_host_model.op(2'h0, 1'b0, 1'b1, AW'(64), '1, 3'h2, '0, 1'b0);
        idle(4);
        chk_bit("queue empty asleep", 1'b0, write_queue_empty);
        chk_bit("queue ready asleep", 1'b1, write_queue_ready);
        sleep_request = 1'b0;
        for (int n = 0; n < 20 && write_queue_empty !== 1'b1; n++) @(negedge mclk);
        chk_bit("queue drained", 1'b1, write_queue_empty);
        rd(1'b0, 64, 1'b1);
        rd(1'b0, 65, 1'b1);
        finish_reads("slept word");
    endtask

    ////////////////////////////////////////////////////////////
    // clock, watchdog and main sequence
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end

    initial begin
        mismatches = 0;
        checks_done = 0;
        cycles = 0;
        reset = 1'b1;
        sleep_request = 1'b0;
        burst_order = 1'b0;
        output_drive_n = 1'b0;
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        chk_bit("oe after reset", 1'b0, data_oe);
        chk_bit("ready after reset", 1'b1, write_queue_ready);
        chk_bit("empty after reset", 1'b1, write_queue_empty);
        s_basic();
        s_burst();
        s_lanes();
        s_hold();
        s_deselect();
        s_odis();
        s_sleep();
        conclude();
    end
endmodule
